// ==== rtl/sipo_latch.sv ====
// What this block does
// RQ1: Eight-bit shift register feeding a separate eight-bit storage register.
// RQ2: Shift and storage clocks act on rising edges, each independently.
// RQ3: Common clocks: storage takes shift contents from before that shift.
// RQ4: Output enable high puts all parallel outputs in high impedance.
// RQ5: Output enable low drives storage register onto parallel outputs.
// RQ6: Clear low forces every shift stage to zero, overriding shift clock.
// RQ7: Shift edge: first stage takes serial input, others take previous stage.
// RQ8: Storage edge loads all eight stages, regardless of other inputs.
// RQ9: Cascade output always shows last stage; output A is first stage.
// RQ10: Clear leaves storage untouched; zeros appear after next storage edge.
//
// Purpose: Serial-in parallel-out shift register with storage latch
// Assumes: Controller pins are asynchronous to CLK_SYS_I and sampled
// Notes:   Storage snapshots also flow out through a 16-word FIFO
`timescale 1ns/10ps
`include "sipo_defines.svh"
module sipo_latch #(
  parameter int STAGES     = `SIPO_STAGES,
  parameter int FIFO_DEPTH = `SIPO_FIFO_DEPTH
)(
  // Clock and reset
  input  wire logic              CLK_SYS_I,
  input  wire logic              ARST_N_I,
  // Controller pins
  input  wire logic              DATA_IN_BIT_I,
  input  wire logic              SHIFT_CLOCK_I,
  input  wire logic              SHIFT_CLEAR_N_I,
  input  wire logic              STORE_CLOCK_I,
  input  wire logic              OUT_ENABLE_N_I,
  // Parallel three-state outputs
  output logic [STAGES-1:0]      PARALLEL_OUTPUTS_O,
  output logic [STAGES-1:0]      PARALLEL_OE_O,
  // Cascade output
  output logic                   CASCADE_OUT_O,
  // Snapshot stream
  output logic                   SNAP_VALID_O,
  output logic [STAGES-1:0]      SNAP_DATA_O,
  input  wire logic              SNAP_READY_I,
  output logic                   SNAP_OVERRUN_O
);
  sipo_pkg::sipo_pins_t raw_pins;
  sipo_pkg::sipo_pins_t sync1_reg;
  sipo_pkg::sipo_pins_t sync2_reg;
  sipo_pkg::sipo_pins_t prev_reg;
  logic [STAGES-1:0]    shift_reg;
  logic [STAGES-1:0]    store_reg;
  logic [STAGES-1:0]    shift_next;
  logic                 shift_edge;
  logic                 store_edge;
  logic                 fifo_in_ready;
  logic                 fifo_out_valid;
  logic [STAGES-1:0]    fifo_out_data;
  logic                 fifo_pop;
  logic                 snap_valid_reg;
  logic [STAGES-1:0]    snap_data_reg;

  assign raw_pins = '{data_in_bit:   DATA_IN_BIT_I,
                      shift_clock:   SHIFT_CLOCK_I,
                      shift_clear_n: SHIFT_CLEAR_N_I,
                      store_clock:   STORE_CLOCK_I,
                      out_enable_n:  OUT_ENABLE_N_I};

  // Two-flop synchroniser, then a delayed copy for edge detection
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      sync1_reg <= `SIPO_PIN_RESET;
      sync2_reg <= `SIPO_PIN_RESET;
      prev_reg  <= `SIPO_PIN_RESET;
    end
    else
    begin
      sync1_reg <= raw_pins;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // Rising edges only, each clock on its own
  assign shift_edge = sync2_reg.shift_clock && !prev_reg.shift_clock; // RQ2
  assign store_edge = sync2_reg.store_clock && !prev_reg.store_clock; // RQ2
  // Next shift contents: serial bit into stage A
  assign shift_next = {shift_reg[STAGES-2:0], sync2_reg.data_in_bit}; // RQ7

  // Shift register with overriding clear
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      shift_reg <= `SIPO_ZERO_BYTE;
    end
    else if (!sync2_reg.shift_clear_n)
    begin
      shift_reg <= `SIPO_ZERO_BYTE; // RQ6
    end
    else if (shift_edge)
    begin
      shift_reg <= shift_next; // RQ1 RQ7
    end
  end

  // Storage register loads old shift contents; clear does not touch it
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      store_reg <= `SIPO_ZERO_BYTE;
    end
    else if (store_edge)
    begin
      store_reg <= shift_reg; // RQ1 RQ3 RQ8 RQ10
    end
  end

  // Registered pin drivers
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      PARALLEL_OUTPUTS_O <= `SIPO_ZERO_BYTE;
      PARALLEL_OE_O      <= `SIPO_ZERO_BYTE;
      CASCADE_OUT_O      <= 1'b0;
    end
    else
    begin
      PARALLEL_OUTPUTS_O <= store_edge ? shift_reg : store_reg; // RQ5
      PARALLEL_OE_O      <= {STAGES{!sync2_reg.out_enable_n}}; // RQ4 RQ5
      CASCADE_OUT_O      <= !sync2_reg.shift_clear_n ? 1'b0 :
                            (shift_edge ? shift_next[STAGES-1] : shift_reg[STAGES-1]); // RQ9
    end
  end

  // Snapshot FIFO: each storage load is queued for the consumer unless the FIFO is full
  sipo_fifo #(
    .WIDTH (STAGES),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CLK_SYS_I),
    .arst_n_i    (ARST_N_I),
    .in_valid_i  (store_edge),
    .in_data_i   (shift_reg),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (fifo_out_valid),
    .out_data_o  (fifo_out_data),
    .out_ready_i (fifo_pop)
  );

  // Output skid stage so the stream ports come from flops
  assign fifo_pop = fifo_out_valid && (!snap_valid_reg || SNAP_READY_I);
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      snap_valid_reg <= 1'b0;
      snap_data_reg  <= `SIPO_ZERO_BYTE;
      SNAP_OVERRUN_O <= 1'b0;
    end
    else
    begin
      if (fifo_pop)
      begin
        snap_valid_reg <= 1'b1;
        snap_data_reg  <= fifo_out_data;
      end
      else if (SNAP_READY_I)
      begin
        snap_valid_reg <= 1'b0;
      end
      if (store_edge && !fifo_in_ready)
      begin
        SNAP_OVERRUN_O <= 1'b1; // Sticky: snapshot dropped, FIFO full
      end
    end
  end
  assign SNAP_VALID_O = snap_valid_reg;
  assign SNAP_DATA_O  = snap_data_reg;
endmodule

// Valid/ready FIFO holding storage-register snapshots; depth a power of two
module sipo_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  // Fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Drain side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // Honest full and empty from the fill count
  assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Storage array
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // Pointers and count
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + (AW+1)'(1);
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - (AW+1)'(1);
      end
    end
  end
endmodule

// ==== rtl/sipo_defines.svh ====
// Purpose: Constants for the serial-in parallel-out latch block
// Assumes: 100 MHz system clock
// Notes:   Included by the package and the top module
`ifndef SIPO_DEFINES_SVH
`define SIPO_DEFINES_SVH
`define SIPO_STAGES     8
`define SIPO_FIFO_DEPTH 16
`define SIPO_SYNC_STAGES 2
`define SIPO_ZERO_BYTE  8'h00
`define SIPO_PIN_RESET  5'h05 // Idle pins: clocks low, clear and enable inactive
`endif

// ==== rtl/sipo_pkg.sv ====
// Purpose: Types for the serial-in parallel-out latch block
// Assumes: sipo_defines.svh gives the stage count
// Notes:   Pin group sampled from the outside controller
`include "sipo_defines.svh"
package sipo_pkg;
  typedef logic [`SIPO_STAGES-1:0] sipo_byte_t;
  // Synchronised input pins from the controller
  typedef struct packed {
    logic data_in_bit;
    logic shift_clock;
    logic shift_clear_n;
    logic store_clock;
    logic out_enable_n;
  } sipo_pins_t;
endpackage

// ==== rtl/sipo_fifo.sv ====
// Purpose: Holds no logic of its own
// Assumes: The snapshot FIFO module sits beside the latch in sipo_latch.sv
// Notes:   All logic of the block is kept in one design file

// ==== test/sipo_latch_assertions.sv ====
// Purpose: Port checks for the latch
// Assumes: Pin events reach outputs three edges later, seen by checks on the fourth
// Notes:   Bound from tb
`timescale 1ns/10ps
module sipo_chk #(parameter int STAGES = 8) (
  // Clock, reset and pins
  input wire logic              CLK_SYS_I,
  input wire logic              ARST_N_I,
  input wire logic              SHIFT_CLOCK_I,
  input wire logic              SHIFT_CLEAR_N_I,
  input wire logic              STORE_CLOCK_I,
  input wire logic              OUT_ENABLE_N_I,
  // Outputs and snapshot ready
  input wire logic [STAGES-1:0] PARALLEL_OUTPUTS_O,
  input wire logic [STAGES-1:0] PARALLEL_OE_O,
  input wire logic              CASCADE_OUT_O,
  input wire logic              SNAP_VALID_O,
  input wire logic [STAGES-1:0] SNAP_DATA_O,
  input wire logic              SNAP_READY_I,
  input wire logic              SNAP_OVERRUN_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!ARST_N_I);
  // Enable and drive relations
  chk_oe_off: assert property (OUT_ENABLE_N_I [*6] |-> PARALLEL_OE_O == '0)
    else $error("Outputs driven while disabled");
  chk_oe_on: assert property ((!OUT_ENABLE_N_I) [*6] |-> PARALLEL_OE_O == '1)
    else $error("Outputs not driven while enabled");
  chk_oe_whole: assert property (PARALLEL_OE_O == '0 || PARALLEL_OE_O == '1)
    else $error("Enables split");
  // Register update causes
  chk_clear_casc: assert property ((!SHIFT_CLEAR_N_I) [*6] |-> !CASCADE_OUT_O)
    else $error("Cascade not cleared");
  // A pin rise between the 4th and 3rd edge back shows as a change seen now
  chk_par_cause: assert property ($changed(PARALLEL_OUTPUTS_O) |->
    $past(STORE_CLOCK_I, 3) && !$past(STORE_CLOCK_I, 4))
    else $error("Outputs moved without store edge");
  chk_casc_cause: assert property ($changed(CASCADE_OUT_O) |->
    ($past(SHIFT_CLOCK_I, 3) && !$past(SHIFT_CLOCK_I, 4)) || !$past(SHIFT_CLEAR_N_I, 3))
    else $error("Cascade moved without cause");
  // Snapshot stream
  chk_snap_hold: assert property (SNAP_VALID_O && !SNAP_READY_I |=>
    SNAP_VALID_O && $stable(SNAP_DATA_O))
    else $error("Snapshot dropped while stalled");
  chk_ovr_sticky: assert property (SNAP_OVERRUN_O |=> SNAP_OVERRUN_O)
    else $error("Overrun flag fell");
  cover property ($rose(SNAP_VALID_O));
  cover property ($rose(SNAP_OVERRUN_O));
  cover property (!SHIFT_CLEAR_N_I ##1 SHIFT_CLEAR_N_I);
endmodule

// ==== test/sipo_ctrl_model.sv ====
// Purpose: Controller driving the latch pins
// Assumes: Levels change one ns after an edge
// Notes:   Clock pulses four cycles high, six or more low
`timescale 1ns/10ps
module sipo_ctrl_model (
  // Clock
  input wire logic clk_i,
  // Pins
  output logic     data_o,
  output logic     sclk_o,
  output logic     clr_n_o,
  output logic     rclk_o,
  output logic     oe_n_o
);
  initial {data_o, sclk_o, clr_n_o, rclk_o, oe_n_o} = 5'h05;
  // Wait n edges, then step off the edge
  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Data set up ahead of the rise, inverted once held long enough
  task automatic pulse(input logic s, input logic r, input logic b);
    data_o = b;
    hold(2);
    sclk_o = s;
    rclk_o = r;
    hold(4);
    sclk_o = 0;
    rclk_o = 0;
    hold(2);
    data_o = ~b; // Moves well after the synchronised rise, never with a new bit
    hold(2);
  endtask
  // Clear pulse longer than the sync path
  task automatic clear();
    clr_n_o = 0;
    hold(6);
    clr_n_o = 1;
    hold(4);
  endtask
  task automatic set_oe(input logic v);
    oe_n_o = v;
    hold(8);
  endtask
endmodule

// ==== test/tb.sv ====
// Purpose: Self-checking bench for the latch
// Assumes: Model of shift, storage and FIFO in the bench
// Notes:   Snapshots checked as they leave
`timescale 1ns/10ps
module tb;
  logic       clk_sys, arst_n, snap_ready, d, sc, cl_n, rc, oe_n, casc, snap_v, ovr;
  logic [7:0] par, par_oe, snap, sh, st, b;
  logic [7:0] q[$];
  int         n_mismatch, comparisons, i, ovr_m;
  sipo_ctrl_model i_sipo_ctrl_model (.clk_i(clk_sys), .data_o(d), .sclk_o(sc),
    .clr_n_o(cl_n), .rclk_o(rc), .oe_n_o(oe_n));
  sipo_latch i_sipo_latch (.CLK_SYS_I(clk_sys), .ARST_N_I(arst_n), .DATA_IN_BIT_I(d),
    .SHIFT_CLOCK_I(sc), .SHIFT_CLEAR_N_I(cl_n), .STORE_CLOCK_I(rc), .OUT_ENABLE_N_I(oe_n),
    .PARALLEL_OUTPUTS_O(par), .PARALLEL_OE_O(par_oe), .CASCADE_OUT_O(casc),
    .SNAP_VALID_O(snap_v), .SNAP_DATA_O(snap), .SNAP_READY_I(snap_ready),
    .SNAP_OVERRUN_O(ovr));
  initial
  begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Model update, one pulse, then compare
  task automatic step(input logic s, input logic r, input logic bit_v);
    if (r)
    begin
      st = sh;
      if (q.size() < 17) // Sixteen FIFO words plus the output register
        q.push_back(sh);
      else
        ovr_m = 1;
    end
    if (s)
      sh = {sh[6:0], bit_v};
    i_sipo_ctrl_model.pulse(s, r, bit_v);
    chk("par", par, st);
    chk("casc", 8'(casc), 8'(sh[7]));
  endtask
  // Each accepted snapshot against the model queue
  always @(posedge clk_sys)
    if (snap_v === 1'b1 && snap_ready === 1'b1)
      chk("snap", snap, q.size() > 0 ? q.pop_front() : 8'hxx);
  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end
  initial
  begin
    {arst_n, snap_ready, sh, st, ovr_m, n_mismatch, comparisons} = '0;
    void'($urandom(32'h614e5b2b));
    repeat (8) @(posedge clk_sys);
    #1 arst_n = 1;
    snap_ready = 1;
    i_sipo_ctrl_model.set_oe(0);
    chk("oe_on", par_oe, 8'hff);
    for (i = 0; i < 32; i++)
    begin
      b = 8'($urandom);
      step(1, 0, b[i%8]);
      if (i % 8 == 7)
        step(0, 1, 0);
    end
    $display("Test shift_store done");
    repeat (6) step(1, 1, 1'($urandom));
    $display("Test common_clock done");
    i_sipo_ctrl_model.clear();
    sh = 0;
    chk("clr_casc", 8'(casc), 8'h00);
    chk("clr_par", par, st);
    step(0, 1, 0);
    $display("Test clear done");
    i_sipo_ctrl_model.set_oe(1);
    chk("oe_off", par_oe, 8'h00);
    i_sipo_ctrl_model.set_oe(0);
    $display("Test enable done");
    snap_ready = 0;
    repeat (18) step(1, 1, 1'($urandom));
    chk("ovr", 8'(ovr), 8'(ovr_m));
    for (i = 0; i < 400 && q.size() > 0; i++)
    begin
      snap_ready = 1'($urandom);
      i_sipo_ctrl_model.hold(1);
    end
    snap_ready = 1;
    i_sipo_ctrl_model.hold(4);
    chk("drained", 8'(q.size()), 8'h00);
    $display("Test fifo done");
    tally_and_finish();
  end
endmodule
bind sipo_latch sipo_chk #(.STAGES(STAGES)) i_sipo_chk (
  .CLK_SYS_I          (CLK_SYS_I),
  .ARST_N_I           (ARST_N_I),
  .SHIFT_CLOCK_I      (SHIFT_CLOCK_I),
  .SHIFT_CLEAR_N_I    (SHIFT_CLEAR_N_I),
  .STORE_CLOCK_I      (STORE_CLOCK_I),
  .OUT_ENABLE_N_I     (OUT_ENABLE_N_I),
  .PARALLEL_OUTPUTS_O (PARALLEL_OUTPUTS_O),
  .PARALLEL_OE_O      (PARALLEL_OE_O),
  .CASCADE_OUT_O      (CASCADE_OUT_O),
  .SNAP_VALID_O       (SNAP_VALID_O),
  .SNAP_DATA_O        (SNAP_DATA_O),
  .SNAP_READY_I       (SNAP_READY_I),
  .SNAP_OVERRUN_O     (SNAP_OVERRUN_O)
);
